// file: hw/dpsr_defs.svh
// named constants for the dual-port static ram port controller
// assumes a 20 MHz controller clock and one ram port per controller
`ifndef DPSR_DEFS_SVH
`define DPSR_DEFS_SVH

// ==========================================================
// array geometry, deep and wide variant
`define DPSR_ADDR_W 16
`define DPSR_ADDR_W_SHALLOW 15
`define DPSR_DATA_W 18
`define DPSR_LANE_W 9
`define DPSR_LANE_W_NARROW 8
`define DPSR_TOKEN_COUNT 8
`define DPSR_TOKEN_SEL_W 3

// ==========================================================
// timing, times in ns
`define DPSR_CLK_NS 32'h0000_0032
`define DPSR_ACCESS_NS 32'h0000_0014
`define DPSR_CNT_W 4
// least access time rounds up to whole cycles
`define DPSR_ACC_CYC_RAW ((`DPSR_ACCESS_NS + `DPSR_CLK_NS - 32'h0000_0001) / `DPSR_CLK_NS)
`define DPSR_ACC_CYC 4'((`DPSR_ACC_CYC_RAW > 32'h0000_0000) ? `DPSR_ACC_CYC_RAW : 32'h0000_0001)
`define DPSR_SYNC_CYC 4'h2
`define DPSR_RECOVER_CYC 4'h1
`define DPSR_RETRY_MAX 4'h8
`define DPSR_CNT_ZERO 4'h0
`define DPSR_CNT_ONE 4'h1

`endif

// file: hw/dpsr_pkg.sv
// types shared by the port controller, its checker, the ram model and the bench
// constants live in dpsr_defs.svh
`include "dpsr_defs.svh"

package dpsr_pkg;

    // ==========================================================
    // user request and answer
    typedef struct packed {
        logic write;
        logic token;
        logic [`DPSR_ADDR_W-1:0] addr;
        logic [`DPSR_DATA_W-1:0] wdata;
        logic upper;
        logic lower;
    } dpsr_req_type;

    typedef struct packed {
        logic valid;
        logic busy;
        logic [`DPSR_DATA_W-1:0] rdata;
    } dpsr_resp_type;

    // ==========================================================
    // pins driven towards the ram port
    typedef struct packed {
        logic chip_sel_low_active_n;
        logic chip_sel_high_active;
        logic read_not_write;
        logic out_en_n;
        logic upper_lane_sel_n;
        logic lower_lane_sel_n;
        logic token_latch_sel_n;
        logic [`DPSR_ADDR_W-1:0] addr;
        logic [`DPSR_DATA_W-1:0] wdata;
        logic data_oe_n;
    } dpsr_pins_type;

    typedef enum logic [2:0] {
        DPSR_IDLE,
        DPSR_SETUP,
        DPSR_ACCESS,
        DPSR_HOLD,
        DPSR_RECOVER
    } dpsr_state_type;

    typedef struct packed {
        dpsr_state_type state;
        logic [`DPSR_CNT_W-1:0] cnt;
        logic [`DPSR_CNT_W-1:0] retries;
        dpsr_req_type req;
        dpsr_pins_type pins;
        dpsr_resp_type resp;
        logic master_sel;
    } dpsr_ctrl_type;

endpackage : dpsr_pkg

// file: hw/dpsr_sync.sv
// two-flop synchroniser for pins arriving from the ram
// assumes the inputs are asynchronous to clk_in
`timescale 1ns/1ps

module dpsr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } dpsr_sync_type;

    dpsr_sync_type sync_reg;
    dpsr_sync_type sync_next;

    // ==========================================================
    // first stage feeds only the second stage
    always_comb begin
        sync_next = sync_reg;
        sync_next.first = async_in;
        sync_next.second = sync_reg.first;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // reset to the pin's idle level so no false flag follows reset
            sync_reg <= '{first: RESET_VAL, second: RESET_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.second;

endmodule : dpsr_sync

// file: hw/dpsr_port_ctrl.sv
// host controller that drives one port of an asynchronous dual-port static ram
// assumes the ram pins are asynchronous; busy and interrupt come back on pins
// What the datasheet requires
// RULE1 - each port reads or writes independently
// RULE2 - same word reachable from both ports
// RULE3 - 32K/64K words, 16/18 bits wide
// RULE4 - selected: first enable low, second high
// RULE5 - upper and lower selects gate lanes
// RULE6 - busy flags access to contested location
// RULE7 - busy pin output as master, input slave
// RULE8 - master/slave select allows wider gangs
// RULE9 - interrupt flag carries mailbox between ports
// RULE10 - eight shared semaphore latches
// RULE11 - each latch owned by one port
// RULE12 - semaphore enable steers to latches
// RULE13 - deselected port enters low power
// RULE14 - on-chip arbitration on same data
// RULE15 - read/write chooses, output enable drives
// RULE16 - device drives data only when reading
// RULE17 - busy port's write is inhibited
`timescale 1ns/1ps
`include "dpsr_defs.svh"

module dpsr_port_ctrl (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // user request
    input wire logic req_valid_in,
    input wire dpsr_pkg::dpsr_req_type req_in,
    output logic req_ready_out,
    // user answer
    output dpsr_pkg::dpsr_resp_type resp_out,
    output logic mailbox_int_out,
    // configuration strap
    input wire logic master_sel_in,
    output logic master_sel_out,
    // ram control pins
    output logic chip_sel_low_active_n_out,
    output logic chip_sel_high_active_out,
    output logic read_not_write_out,
    output logic out_en_n_out,
    output logic upper_lane_sel_n_out,
    output logic lower_lane_sel_n_out,
    output logic token_latch_sel_n_out,
    output logic [`DPSR_ADDR_W-1:0] addr_out,
    // ram data pins, three signals per two-way pin
    input wire logic [`DPSR_DATA_W-1:0] data_in,
    output logic [`DPSR_DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    // ram flags
    input wire logic busy_n_in,
    input wire logic int_n_in
);
    import dpsr_pkg::*;

    dpsr_ctrl_type ctrl_reg;
    dpsr_ctrl_type ctrl_next;
    logic [`DPSR_DATA_W-1:0] data_sync;
    logic busy_n_sync;
    logic int_n_sync;
    logic [`DPSR_CNT_W-1:0] access_len;

    // ==========================================================
    // pin synchronisers
    dpsr_sync #(
        .WIDTH(`DPSR_DATA_W)
    ) u_data_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(data_in),
        .sync_out(data_sync)
    );

    // RULE7 busy read back
    dpsr_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_busy_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(busy_n_in),
        .sync_out(busy_n_sync)
    );

    // RULE9 mailbox flag
    dpsr_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_int_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(int_n_in),
        .sync_out(int_n_sync)
    );

    // access lasts the ram access time plus the synchroniser delay, so that
    // busy and read data seen at the end belong to this very access
    assign access_len = `DPSR_ACC_CYC + `DPSR_SYNC_CYC;

    // ==========================================================
    // sequencer
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next.resp.valid = 1'b0;
        ctrl_next.master_sel = master_sel_in;
        case (ctrl_reg.state)
            DPSR_IDLE: begin
                if (req_valid_in) begin
                    ctrl_next.req = req_in;
                    ctrl_next.retries = `DPSR_CNT_ZERO;
                    ctrl_next.state = DPSR_SETUP;
                    ctrl_next.pins.addr = req_in.addr;
                    ctrl_next.pins.wdata = req_in.wdata;
                    ctrl_next.pins.read_not_write = 1'b1;
                    ctrl_next.pins.out_en_n = 1'b1;
                    // RULE12 token access path
                    if (req_in.token) begin
                        ctrl_next.pins.token_latch_sel_n = 1'b0;
                    end else begin
                        // RULE4 select the port
                        ctrl_next.pins.chip_sel_low_active_n = 1'b0;
                        ctrl_next.pins.chip_sel_high_active = 1'b1;
                    end
                    // RULE5 lane gating
                    ctrl_next.pins.upper_lane_sel_n = !req_in.upper;
                    ctrl_next.pins.lower_lane_sel_n = !req_in.lower;
                end
            end
            DPSR_SETUP: begin
                ctrl_next.cnt = `DPSR_CNT_ZERO;
                ctrl_next.state = DPSR_ACCESS;
                // RULE15 choose read or write
                if (ctrl_reg.req.write) begin
                    ctrl_next.pins.read_not_write = 1'b0;
                    ctrl_next.pins.data_oe_n = 1'b0;
                end else begin
                    // RULE16 ram drives only on read
                    ctrl_next.pins.out_en_n = 1'b0;
                end
            end
            DPSR_ACCESS: begin
                ctrl_next.cnt = ctrl_reg.cnt + `DPSR_CNT_ONE;
                if (ctrl_reg.cnt == access_len - `DPSR_CNT_ONE) begin
                    ctrl_next.state = DPSR_HOLD;
                    // end write first, keep data driven one more cycle for hold
                    ctrl_next.pins.read_not_write = 1'b1;
                    ctrl_next.pins.out_en_n = 1'b1;
                    ctrl_next.resp.rdata = data_sync;
                    // RULE6 lost arbitration seen
                    ctrl_next.resp.busy = !busy_n_sync;
                end
            end
            DPSR_HOLD: begin
                ctrl_next.pins.data_oe_n = 1'b1;
                ctrl_next.cnt = `DPSR_CNT_ZERO;
                // RULE17 contested write repeated
                if (ctrl_reg.req.write && ctrl_reg.resp.busy
                        && ctrl_reg.retries != `DPSR_RETRY_MAX) begin
                    ctrl_next.retries = ctrl_reg.retries + `DPSR_CNT_ONE;
                    ctrl_next.state = DPSR_SETUP;
                end else begin
                    // RULE13 deselect for low power
                    ctrl_next.pins.chip_sel_low_active_n = 1'b1;
                    ctrl_next.pins.chip_sel_high_active = 1'b0;
                    ctrl_next.pins.token_latch_sel_n = 1'b1;
                    ctrl_next.pins.upper_lane_sel_n = 1'b1;
                    ctrl_next.pins.lower_lane_sel_n = 1'b1;
                    ctrl_next.resp.valid = 1'b1;
                    ctrl_next.state = DPSR_RECOVER;
                end
            end
            DPSR_RECOVER: begin
                // a deselected gap lets the other side see the token change
                ctrl_next.cnt = ctrl_reg.cnt + `DPSR_CNT_ONE;
                if (ctrl_reg.cnt == `DPSR_RECOVER_CYC - `DPSR_CNT_ONE) begin
                    ctrl_next.state = DPSR_IDLE;
                end
            end
            default: begin
                ctrl_next.state = DPSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= '0;
            ctrl_reg.state <= DPSR_IDLE;
            ctrl_reg.pins.chip_sel_low_active_n <= 1'b1;
            ctrl_reg.pins.read_not_write <= 1'b1;
            ctrl_reg.pins.out_en_n <= 1'b1;
            ctrl_reg.pins.upper_lane_sel_n <= 1'b1;
            ctrl_reg.pins.lower_lane_sel_n <= 1'b1;
            ctrl_reg.pins.token_latch_sel_n <= 1'b1;
            ctrl_reg.pins.data_oe_n <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ==========================================================
    // outputs
    assign req_ready_out = (ctrl_reg.state == DPSR_IDLE);
    assign resp_out = ctrl_reg.resp;
    assign mailbox_int_out = !int_n_sync;
    // RULE8 strap passed to the ram
    assign master_sel_out = ctrl_reg.master_sel;
    assign chip_sel_low_active_n_out = ctrl_reg.pins.chip_sel_low_active_n;
    assign chip_sel_high_active_out = ctrl_reg.pins.chip_sel_high_active;
    assign read_not_write_out = ctrl_reg.pins.read_not_write;
    assign out_en_n_out = ctrl_reg.pins.out_en_n;
    assign upper_lane_sel_n_out = ctrl_reg.pins.upper_lane_sel_n;
    assign lower_lane_sel_n_out = ctrl_reg.pins.lower_lane_sel_n;
    assign token_latch_sel_n_out = ctrl_reg.pins.token_latch_sel_n;
    assign addr_out = ctrl_reg.pins.addr;
    assign data_out = ctrl_reg.pins.wdata;
    assign data_oe_n_out = ctrl_reg.pins.data_oe_n;

endmodule : dpsr_port_ctrl

// file: sim/dpsr_port_ctrl_assertions.sv
// port-level checks for the ram port controller
// assumes dpsr_pkg is compiled first; bound to every controller instance
`timescale 1ns/1ps
module dpsr_port_ctrl_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // user side
    input wire logic req_valid_in,
    input wire dpsr_pkg::dpsr_req_type req_in,
    input wire logic req_ready_out,
    input wire dpsr_pkg::dpsr_resp_type resp_out,
    input wire logic mailbox_int_out,
    input wire logic int_n_in,
    // ram pins
    input wire logic chip_sel_low_active_n_out,
    input wire logic chip_sel_high_active_out,
    input wire logic read_not_write_out,
    input wire logic out_en_n_out,
    input wire logic upper_lane_sel_n_out,
    input wire logic lower_lane_sel_n_out,
    input wire logic token_latch_sel_n_out,
    input wire logic data_oe_n_out
);
    import dpsr_pkg::*;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire take = req_valid_in && req_ready_out;
    chip_select_a: assert property (
        take && !req_in.token |=> !chip_sel_low_active_n_out && chip_sel_high_active_out)
        else $error("chip enables not active after take");
    token_steer_a: assert property (
        take && req_in.token |=> !token_latch_sel_n_out && chip_sel_low_active_n_out)
        else $error("token access not steered to latches");
    read_answer_a: assert property (
        take && !req_in.write |=> !resp_out.valid [*5] ##1 resp_out.valid)
        else $error("read answer not six cycles after take");
    lane_select_a: assert property (
        take && !req_in.token |=> upper_lane_sel_n_out == !$past(req_in.upper)
            && lower_lane_sel_n_out == !$past(req_in.lower))
        else $error("lane selects do not follow request");
    no_drive_clash_a: assert property (
        !out_en_n_out |-> data_oe_n_out && read_not_write_out)
        else $error("controller drives data while ram output enabled");
    ready_order_a: assert property (
        resp_out.valid |-> !req_ready_out ##1 req_ready_out)
        else $error("ready not back one cycle after answer");
    mailbox_flag_a: assert property (
        !int_n_in [*4] |-> mailbox_int_out)
        else $error("mailbox flag missing while interrupt pin low");
    power_down_a: assert property (
        resp_out.valid |-> chip_sel_low_active_n_out && !chip_sel_high_active_out
            && token_latch_sel_n_out)
        else $error("port still selected at answer");
endmodule : dpsr_port_ctrl_assertions

bind dpsr_port_ctrl dpsr_port_ctrl_assertions u_chk (.*);

// file: sim/dpsr_ram_model.sv
// behavioural model of one ram port with its token latches and flags
// assumes pins come from dpsr_port_ctrl; busy and interrupt are set by the bench
`timescale 1ns/1ps
`include "dpsr_defs.svh"
module dpsr_ram_model (
    // clock for write sampling
    input wire logic clk_in,
    // pins from the controller
    input wire dpsr_pkg::dpsr_pins_type pins_in,
    // bench controls
    input wire logic busy_set_in,
    input wire logic int_set_in,
    // pins back to the controller
    output logic [`DPSR_DATA_W-1:0] data_out,
    output logic busy_n_out,
    output logic int_n_out
);
    import dpsr_pkg::*;
    logic [`DPSR_DATA_W-1:0] mem [0:65535];
    logic [`DPSR_TOKEN_COUNT-1:0] token_reg = '1;
    logic [`DPSR_DATA_W-1:0] last_reg = '0;
    // selected only low and high enable
    wire sel = !pins_in.chip_sel_low_active_n && pins_in.chip_sel_high_active;
    wire tok = !pins_in.token_latch_sel_n;
    wire [17:0] lmask = {{9{!pins_in.upper_lane_sel_n}}, {9{!pins_in.lower_lane_sel_n}}};
    wire [17:0] rd = tok ? {17'h0_0000, token_reg[pins_in.addr[2:0]]} : mem[pins_in.addr];
    wire drive = (sel || tok) && pins_in.read_not_write && !pins_in.out_en_n && |lmask;
    // released bus shows the inverse so a stale value never passes
    assign data_out = drive ? rd : ~last_reg;
    assign busy_n_out = !(busy_set_in && (sel || tok));
    assign int_n_out = !int_set_in;
    always @(posedge clk_in) begin
        if (drive) begin
            last_reg <= rd;
        end
        if (!pins_in.read_not_write && !pins_in.data_oe_n && !busy_set_in) begin
            if (sel) begin
                mem[pins_in.addr] <= (mem[pins_in.addr] & ~lmask) | (pins_in.wdata & lmask);
            end
            if (tok) begin
                token_reg[pins_in.addr[2:0]] <= pins_in.wdata[0];
            end
        end
    end
endmodule : dpsr_ram_model

// file: sim/dpsr_port_ctrl_tb.sv
// self-checking bench for the ram port controller against the ram model
// assumes the checker binds itself; clock 20 MHz
`timescale 1ns/1ps
module dpsr_port_ctrl_tb;
    import dpsr_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    dpsr_req_type req_in = '0;
    logic master_sel_in = 1'b0;
    logic busy_set = 1'b0;
    logic int_set = 1'b0;
    logic req_ready_out, mailbox_int_out, master_sel_out, busy_n_in, int_n_in;
    dpsr_resp_type resp_out;
    wire dpsr_pins_type p;
    logic [17:0] data_in;
    int miscompares = 0;
    int num_checks = 0;
    always #25 clk_in = ~clk_in;
    dpsr_port_ctrl uut (.*, .chip_sel_low_active_n_out(p.chip_sel_low_active_n),
        .chip_sel_high_active_out(p.chip_sel_high_active), .read_not_write_out(p.read_not_write),
        .out_en_n_out(p.out_en_n), .upper_lane_sel_n_out(p.upper_lane_sel_n),
        .lower_lane_sel_n_out(p.lower_lane_sel_n), .token_latch_sel_n_out(p.token_latch_sel_n),
        .addr_out(p.addr), .data_out(p.wdata), .data_oe_n_out(p.data_oe_n));
    dpsr_ram_model ram (.clk_in(clk_in), .pins_in(p), .busy_set_in(busy_set),
        .int_set_in(int_set), .data_out(data_in), .busy_n_out(busy_n_in), .int_n_out(int_n_in));
    // ==========
    // shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic op(input logic wr, tk, input logic [15:0] a, input logic [17:0] d,
                      input logic up, lo);
        int n;
        @(negedge clk_in);
        req_in = '{write: wr, token: tk, addr: a, wdata: d, upper: up, lower: lo};
        req_valid_in = 1'b1;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        // busy writes retry, so allow the longest answer
        for (n = 0; n < 80 && resp_out.valid !== 1'b1; n++) begin
            @(negedge clk_in);
        end
        if (n == 80) begin
            miscompares++;
            give_verdict();
        end
    endtask : op
    // ==========
    // scenarios
    task automatic t_idle();
        chk("idle pins", 18'h0_002f, {12'h000, p.chip_sel_low_active_n, p.chip_sel_high_active,
            p.token_latch_sel_n, p.data_oe_n, p.out_en_n, req_ready_out});
        $display("test idle done");
    endtask : t_idle
    task automatic t_rw_lanes();
        op(1, 0, 16'hffff, 18'h2_5a5a, 1, 1);
        op(1, 0, 16'h0000, 18'h1_0001, 1, 1);
        op(0, 0, 16'hffff, 18'h0_0000, 1, 1);
        chk("read word", 18'h2_5a5a, resp_out.rdata);
        op(1, 0, 16'hffff, 18'h3_fe00, 1, 0);
        op(0, 0, 16'hffff, 18'h0_0000, 1, 1);
        chk("upper lane", 18'h3_fe00 | (18'h2_5a5a & 18'h0_01ff), resp_out.rdata);
        $display("test rw_lanes done");
    endtask : t_rw_lanes
    task automatic t_token();
        op(1, 1, 16'h0003, 18'h0_0000, 1, 1);
        op(0, 1, 16'h0003, 18'h0_0000, 1, 1);
        chk("token 3", 18'h0_0000, resp_out.rdata);
        op(0, 1, 16'h0005, 18'h0_0000, 1, 1);
        chk("token 5", 18'h0_0001, resp_out.rdata);
        $display("test token done");
    endtask : t_token
    task automatic t_busy();
        busy_set = 1'b1;
        op(1, 0, 16'h0000, 18'h0_1111, 1, 1);
        chk("busy write", 18'h0_0001, {17'h0_0000, resp_out.busy});
        op(0, 0, 16'h0000, 18'h0_0000, 1, 1);
        chk("busy read", 18'h1_0001, resp_out.rdata);
        busy_set = 1'b0;
        op(0, 0, 16'h0000, 18'h0_0000, 1, 1);
        chk("write dropped", 18'h1_0001, resp_out.rdata);
        chk("busy clear", 18'h0_0000, {17'h0_0000, resp_out.busy});
        $display("test busy done");
    endtask : t_busy
    task automatic t_flags();
        int_set = 1'b1;
        master_sel_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk("mailbox on", 18'h0_0001, {17'h0_0000, mailbox_int_out});
        chk("strap", 18'h0_0001, {17'h0_0000, master_sel_out});
        int_set = 1'b0;
        master_sel_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk("mailbox off", 18'h0_0000, {17'h0_0000, mailbox_int_out});
        chk("strap off", 18'h0_0000, {17'h0_0000, master_sel_out});
        $display("test flags done");
    endtask : t_flags
    initial begin
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        t_idle();
        t_rw_lanes();
        t_token();
        t_busy();
        t_flags();
        give_verdict();
    end
endmodule : dpsr_port_ctrl_tb
